//--- verilog/dtei_pkg.sv
// Purpose: Shared constants and types for the dual timer and external interrupt unit
// Assumes: Registers hold 8-bit data in the low byte of a 32-bit Avalon-MM word
// Notes: Register byte address is four times the register index
package dtei_pkg;
    localparam int ADDR_W = 10;
    localparam int DATA_W = 32;
    localparam int IRQ_W = 4;
    localparam int PRE_W = 12;
    // Register indices
    localparam logic [7:0] IDX_TCTL = 8'h88;
    localparam logic [7:0] IDX_TIMER_MODE_SELECT = 8'h89;
    localparam logic [7:0] IDX_TL_A = 8'h8a;
    localparam logic [7:0] IDX_TL_B = 8'h8b;
    localparam logic [7:0] IDX_TH_A = 8'h8c;
    localparam logic [7:0] IDX_TH_B = 8'h8d;
    localparam logic [7:0] IDX_CKPS = 8'h8e;
    localparam logic [7:0] IDX_CLKCFG = 8'h8f;
    localparam logic [7:0] IDX_ISTAT = 8'h90;
    localparam logic [7:0] IDX_IMASK = 8'h91;
    localparam logic [7:0] CKPS_RST = 8'h01;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] BYTE_MAX = 8'hff;
    localparam logic [4:0] LOW5_MAX = 5'h1f;
    localparam logic [15:0] WORD_MAX = 16'hffff;
    localparam logic [1:0] DIV_SLOW = 2'h3;
    localparam logic [1:0] DIV_FULL = 2'h0;
    // Oscillator clocks per timer count
    localparam logic [PRE_W-1:0] PER_STD = 12'h00c;
    localparam logic [PRE_W-1:0] PER_STD_SLOW = 12'hc00;
    localparam logic [PRE_W-1:0] PER_FAST_SLOW = 12'h400;
    localparam logic [PRE_W-1:0] PER_X4 = 12'h001;
    localparam logic [PRE_W-1:0] PER_X2 = 12'h002;
    localparam logic [PRE_W-1:0] PER_DIV = 12'h004;
    // Interrupt status, mask and vector acknowledge bit positions
    localparam int EV_TF_A = 0;
    localparam int EV_TF_B = 1;
    localparam int EV_EX_A = 2;
    localparam int EV_EX_B = 3;

    typedef enum logic [1:0] {DTEI_M13, DTEI_M16, DTEI_M8R, DTEI_MSPLIT} dtei_mode_t;

    typedef struct packed {
        logic timer_b_overflow_flag;
        logic timer_b_run;
        logic timer_a_overflow_flag;
        logic timer_a_run;
        logic ext_irq_b_detect;
        logic ext_irq_b_type;
        logic ext_irq_a_detect;
        logic ext_irq_a_type;
    } dtei_tctl_t;

    typedef struct packed {
        logic gate;
        logic count_sel;
        dtei_mode_t mode;
    } dtei_tmode_t;

    typedef struct packed {
        dtei_tmode_t b;
        dtei_tmode_t a;
    } dtei_timer_mode_select_t;

    typedef struct packed {
        logic [1:0] wdog_sel;
        logic t2_sel;
        logic timer_b_clock_select;
        logic timer_a_clock_select;
        logic [2:0] stretch;
    } dtei_ckps_t;

    typedef struct packed {
        logic [1:0] clock_divider_field;
        logic clock_multiplier_select;
        logic [2:0] unused;
        logic timer_b_high_speed_select;
        logic timer_a_high_speed_select;
    } dtei_clkcfg_t;

    typedef struct packed {
        logic read;
        logic write;
        logic [ADDR_W-1:0] address;
        logic [3:0] byteenable;
        logic [DATA_W-1:0] writedata;
    } dtei_avs_req_t;
endpackage

//--- verilog/dtei_top.sv
// Purpose: Two 8/16-bit timer/counters with external interrupt edge/level detect
// Assumes: Single clock at 100 MHz, Avalon-MM slave with one wait state
// Notes: Pins are synchronised through three flops before use
// Notes on behaviour
// - Timer b overflow sets its flag outside timer a mode 11, where split high byte overflow sets it; software zero or vectoring clears it.
// - Timer a overflow sets its flag; software zero or vectoring clears it.
// - A timer counts only while its run bit is one, else holds; in timer a mode 11 the high byte follows the timer b run bit.
// - Edge type: falling pin edge sets detect flag until cleared or vectored.
// - Level type: detect flag mirrors inverted pin level, no latching.
// - Type bit zero means level, one means edge for each pin.
// - Gate set: timer counts only while run is one and pin high.
// - Count select zero uses prescaled clock, one uses count pin pulses.
// - Mode 00 is 13-bit, 01 is 16-bit, 10 is 8-bit auto-reload.
// - Timer b mode 11 halts timer b and keeps its count.
// - Timer a mode 11 splits bytes; low runs on a, high on b.
// - Count bytes are separate read/write registers resetting to zero.
// - Count period is 12, 1, 2, 4, 3072 or 1024 oscillator clocks.
// - High-speed select clocks the timer every system clock.
//
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/1ns
module dtei_top (
    input wire logic clk,
    input wire logic rst_n,
    input dtei_pkg::dtei_avs_req_t avs_req,
    output logic [dtei_pkg::DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic ext_irq_a_pin,
    input wire logic ext_irq_b_pin,
    input wire logic timer_a_count_pin,
    input wire logic timer_b_count_pin,
    input wire logic [dtei_pkg::IRQ_W-1:0] vec_ack,
    output logic irq
);
    import dtei_pkg::*;

    logic [3:0] pin_raw;
    logic [3:0] s1_r;
    logic [3:0] s2_r;
    logic [3:0] s3_r;
    logic [3:0] pin_f_r;
    logic [3:0] agree;
    logic [3:0] pin_fall;
    logic waitrequest_r;
    logic [DATA_W-1:0] readdata_r;
    logic irq_r;
    dtei_tctl_t tctl_r;
    dtei_tctl_t tctl_nxt;
    dtei_timer_mode_select_t timer_mode_select_r;
    dtei_ckps_t ckps_r;
    dtei_clkcfg_t clkcfg_r;
    logic [IRQ_W-1:0] istat_r;
    logic [IRQ_W-1:0] imask_r;
    logic [IRQ_W-1:0] ev;
    logic [7:0] tl_r [2];
    logic [7:0] th_r [2];
    logic [7:0] tl_nxt [2];
    logic [7:0] th_nxt [2];
    logic [1:0] ovf;
    logic [1:0] tick;
    logic [1:0] hs;
    logic [1:0] csel;
    logic [PRE_W-1:0] pre_r [2];
    logic [7:0] idx;
    logic [7:0] wd;
    logic [7:0] rd_byte;
    logic wr_en;
    logic rd_acc;
    logic wr_cnt;
    logic split;
    logic inc_a;
    logic inc_b;
    logic inc_a_hi;
    logic [16:0] step_a;
    logic [16:0] step_b;

    // Pins idle high; filtered level changes only when flops 2 and 3 agree
    assign pin_raw = {timer_b_count_pin, timer_a_count_pin, ext_irq_b_pin, ext_irq_a_pin};
    assign agree = ~(s2_r ^ s3_r);
    assign pin_fall = agree & ~s3_r & pin_f_r;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            s1_r <= 4'hf;
            s2_r <= 4'hf;
            s3_r <= 4'hf;
            pin_f_r <= 4'hf;
        end
        else
        begin
            s1_r <= pin_raw;
            s2_r <= s1_r;
            s3_r <= s2_r;
            pin_f_r <= (pin_f_r & ~agree) | (s3_r & agree);
        end
    end

    // Bus decode; one wait state on every access
    assign idx = avs_req.address[ADDR_W-1:2];
    assign wd = avs_req.writedata[7:0];
    assign wr_en = avs_req.write && !waitrequest_r && avs_req.byteenable[0];
    assign rd_acc = avs_req.read && !waitrequest_r;
    assign wr_cnt = wr_en && (idx >= IDX_TL_A) && (idx <= IDX_TH_B);

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            waitrequest_r <= 1'b1;
        else
            waitrequest_r <= !((avs_req.read || avs_req.write) && waitrequest_r);
    end

    always_comb
    begin
        case (idx)
            IDX_TCTL: rd_byte = tctl_r;
            IDX_TIMER_MODE_SELECT: rd_byte = timer_mode_select_r;
            IDX_TL_A: rd_byte = tl_r[0];
            IDX_TL_B: rd_byte = tl_r[1];
            IDX_TH_A: rd_byte = th_r[0];
            IDX_TH_B: rd_byte = th_r[1];
            IDX_CKPS: rd_byte = ckps_r;
            IDX_CLKCFG: rd_byte = clkcfg_r;
            IDX_ISTAT: rd_byte = {4'h0, istat_r};
            IDX_IMASK: rd_byte = {4'h0, imask_r};
            default: rd_byte = BYTE_ZERO;
        endcase
    end

    // Data is captured in the waiting cycle so it stands at the accept edge
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            readdata_r <= '0;
        else if (avs_req.read && waitrequest_r)
            readdata_r <= {24'h000000, rd_byte};
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            timer_mode_select_r <= '0;
            ckps_r <= CKPS_RST;
            clkcfg_r <= '0;
            imask_r <= '0;
        end
        else if (wr_en)
        begin
            if (idx == IDX_TIMER_MODE_SELECT)
                timer_mode_select_r <= wd;
            if (idx == IDX_CKPS)
                ckps_r <= wd;
            if (idx == IDX_CLKCFG)
                clkcfg_r <= wd;
            if (idx == IDX_IMASK)
                imask_r <= wd[IRQ_W-1:0];
        end
    end

    function automatic logic [PRE_W-1:0] period(input logic sel, input dtei_clkcfg_t c);
        if (!sel)
            period = (c.clock_divider_field == DIV_SLOW) ? PER_STD_SLOW : PER_STD;
        else if (c.clock_divider_field == DIV_SLOW)
            period = PER_FAST_SLOW;
        else if (c.clock_divider_field == DIV_FULL)
            period = c.clock_multiplier_select ? PER_X4 : PER_X2;
        else
            period = PER_DIV;
    endfunction

    assign hs = {clkcfg_r.timer_b_high_speed_select, clkcfg_r.timer_a_high_speed_select};
    assign csel = {ckps_r.timer_b_clock_select, ckps_r.timer_a_clock_select};

    generate
        for (genvar g = 0; g < 2; g++)
        begin : g_pre
            logic [PRE_W-1:0] per;
            logic hit;
            assign per = period(csel[g], clkcfg_r);
            assign hit = pre_r[g] >= (per - PER_X4);
            assign tick[g] = hs[g] || hit;
            always_ff @(posedge clk)
            begin
                if (!rst_n || hit)
                    pre_r[g] <= '0;
                else
                    pre_r[g] <= pre_r[g] + PER_X4;
            end
        end
    endgenerate

    // one count step; bit 16 is the wrap
    function automatic logic [16:0] step(input dtei_mode_t m, input logic [7:0] tl,
                                         input logic [7:0] th, input logic inc);
        logic [16:0] r;
        r = {1'b0, th, tl};
        if (inc)
        begin
            unique case (m)
                DTEI_M13:
                begin
                    r[4:0] = tl[4:0] + 5'h01;
                    if (tl[4:0] == LOW5_MAX)
                    begin
                        r[15:8] = th + 8'h01;
                        r[16] = (th == BYTE_MAX);
                    end
                end
                DTEI_M16: r = {({th, tl} == WORD_MAX), {th, tl} + 16'h0001};
                DTEI_M8R:
                begin
                    r[7:0] = (tl == BYTE_MAX) ? th : tl + 8'h01;
                    r[16] = (tl == BYTE_MAX);
                end
                DTEI_MSPLIT:
                begin
                    r[7:0] = tl + 8'h01;
                    r[16] = (tl == BYTE_MAX);
                end
            endcase
        end
        return r;
    endfunction

    assign split = (timer_mode_select_r.a.mode == DTEI_MSPLIT);
    assign inc_a = tctl_r.timer_a_run && (!timer_mode_select_r.a.gate || pin_f_r[0])
                   && (timer_mode_select_r.a.count_sel ? pin_fall[2] : tick[0]);
    // timer b halted in mode 11
    assign inc_b = tctl_r.timer_b_run && (!timer_mode_select_r.b.gate || pin_f_r[1])
                   && (timer_mode_select_r.b.count_sel ? pin_fall[3] : tick[1])
                   && (timer_mode_select_r.b.mode != DTEI_MSPLIT);
    // split high byte runs on timer b run
    assign inc_a_hi = split && tctl_r.timer_b_run && tick[0];
    assign step_a = step(timer_mode_select_r.a.mode, tl_r[0], th_r[0], inc_a);
    assign step_b = step(timer_mode_select_r.b.mode, tl_r[1], th_r[1], inc_b);

    always_comb
    begin
        tl_nxt[0] = step_a[7:0];
        tl_nxt[1] = step_b[7:0];
        th_nxt[1] = step_b[15:8];
        ovf[0] = step_a[16];
        if (split)
        begin
            // split high byte owns the timer b flag
            th_nxt[0] = th_r[0] + {7'h00, inc_a_hi};
            ovf[1] = inc_a_hi && (th_r[0] == BYTE_MAX);
        end
        else
        begin
            th_nxt[0] = step_a[15:8];
            ovf[1] = step_b[16];
        end
    end

    // bus write wins over counting in the same cycle
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            tl_r[0] <= '0;
            tl_r[1] <= '0;
            th_r[0] <= '0;
            th_r[1] <= '0;
        end
        else
        begin
            tl_r[0] <= (wr_en && idx == IDX_TL_A) ? wd : tl_nxt[0];
            tl_r[1] <= (wr_en && idx == IDX_TL_B) ? wd : tl_nxt[1];
            th_r[0] <= (wr_en && idx == IDX_TH_A) ? wd : th_nxt[0];
            th_r[1] <= (wr_en && idx == IDX_TH_B) ? wd : th_nxt[1];
        end
    end

    // Flag set wins over software or vector clear
    always_comb
    begin
        logic wt;
        dtei_tctl_t w;
        wt = wr_en && (idx == IDX_TCTL);
        w = wd;
        tctl_nxt = tctl_r;
        if (wt)
        begin
            tctl_nxt = w;
        end
        else
        begin
            tctl_nxt.timer_a_overflow_flag = tctl_r.timer_a_overflow_flag && !vec_ack[EV_TF_A];
            tctl_nxt.timer_b_overflow_flag = tctl_r.timer_b_overflow_flag && !vec_ack[EV_TF_B];
            tctl_nxt.ext_irq_a_detect = tctl_r.ext_irq_a_detect && !vec_ack[EV_EX_A];
            tctl_nxt.ext_irq_b_detect = tctl_r.ext_irq_b_detect && !vec_ack[EV_EX_B];
        end
        tctl_nxt.timer_a_overflow_flag = tctl_nxt.timer_a_overflow_flag || ovf[0];
        tctl_nxt.timer_b_overflow_flag = tctl_nxt.timer_b_overflow_flag || ovf[1];
        if (tctl_r.ext_irq_a_type)
            tctl_nxt.ext_irq_a_detect = tctl_nxt.ext_irq_a_detect || pin_fall[0];
        else
            tctl_nxt.ext_irq_a_detect = !pin_f_r[0];
        if (tctl_r.ext_irq_b_type)
            tctl_nxt.ext_irq_b_detect = tctl_nxt.ext_irq_b_detect || pin_fall[1];
        else
            tctl_nxt.ext_irq_b_detect = !pin_f_r[1];
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            tctl_r <= '0;
        else
            tctl_r <= tctl_nxt;
    end

    // Events are overflow pulses and rising detect flags; read clears only bits the reader saw
    assign ev = {tctl_nxt.ext_irq_b_detect && !tctl_r.ext_irq_b_detect,
                 tctl_nxt.ext_irq_a_detect && !tctl_r.ext_irq_a_detect,
                 ovf[1], ovf[0]};

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            istat_r <= '0;
            irq_r <= 1'b0;
        end
        else
        begin
            if (rd_acc && idx == IDX_ISTAT)
                istat_r <= (istat_r & ~readdata_r[IRQ_W-1:0]) | ev;
            else
                istat_r <= istat_r | ev;
            irq_r <= |(istat_r & imask_r);
        end
    end

    assign avs_readdata = readdata_r;
    assign avs_waitrequest = waitrequest_r;
    assign irq = irq_r;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_tf_b_set;
        ovf[1] |=> tctl_r.timer_b_overflow_flag;
    endproperty
    a_tf_b_set: assert property (p_tf_b_set) else $error("timer b flag not set");
    property p_tf_a_ack;
        !ovf[0] && vec_ack[EV_TF_A] && !(wr_en && idx == IDX_TCTL) |=> !tctl_r.timer_a_overflow_flag;
    endproperty
    a_tf_a_ack: assert property (p_tf_a_ack) else $error("timer a flag not cleared");
    property p_halt_a;
        !tctl_r.timer_a_run && !wr_cnt |=> tl_r[0] == $past(tl_r[0]);
    endproperty
    a_halt_a: assert property (p_halt_a) else $error("halted timer a moved");
    property p_edge_a;
        tctl_r.ext_irq_a_type && pin_fall[0] |=> tctl_r.ext_irq_a_detect;
    endproperty
    a_edge_a: assert property (p_edge_a) else $error("edge not latched");
    property p_level_a;
        !tctl_r.ext_irq_a_type |=> tctl_r.ext_irq_a_detect == !$past(pin_f_r[0]);
    endproperty
    a_level_a: assert property (p_level_a) else $error("level not mirrored");
    property p_gate_a;
        timer_mode_select_r.a.gate && !pin_f_r[0] && !wr_cnt |=> $stable(tl_r[0]);
    endproperty
    a_gate_a: assert property (p_gate_a) else $error("gated timer a moved");
    property p_b_mode3;
        timer_mode_select_r.b.mode == DTEI_MSPLIT && !wr_cnt |=> $stable(tl_r[1]) && $stable(th_r[1]);
    endproperty
    a_b_mode3: assert property (p_b_mode3) else $error("timer b moved in mode 11");
    property p_split_hi;
        inc_a_hi && th_r[0] != BYTE_MAX && !wr_cnt |=> th_r[0] == $past(th_r[0]) + 8'h01;
    endproperty
    a_split_hi: assert property (p_split_hi) else $error("split high byte wrong");
    sequence s_reload;
        timer_mode_select_r.a.mode == DTEI_M8R && inc_a && tl_r[0] == BYTE_MAX && !wr_cnt;
    endsequence
    property p_reload;
        s_reload |=> tl_r[0] == $past(th_r[0]) && tctl_r.timer_a_overflow_flag;
    endproperty
    a_reload: assert property (p_reload) else $error("reload or flag missing");
    sequence s_req;
        (avs_req.read || avs_req.write) && waitrequest_r;
    endsequence
    property p_bus;
        s_req |=> !avs_waitrequest ##1 avs_waitrequest;
    endproperty
    a_bus: assert property (p_bus) else $error("wait state sequence wrong");
endmodule

//--- sim/dtei_pins.sv
// Purpose: Pin-side model for the interrupt and count inputs
// Assumes: Interrupt lines are pulled up, so they idle high
// Notes: Pins change only just after a rising clock edge
`timescale 1ns/1ns
module dtei_pins (
    input wire logic clk,
    output logic ext_a,
    output logic ext_b,
    output logic cnt_a,
    output logic cnt_b
);
    initial
    begin
        ext_a = 1'b1;
        ext_b = 1'b1;
        cnt_a = 1'b1;
        cnt_b = 1'b1;
    end

    task automatic set_ext(input logic a, input logic b);
        @(posedge clk);
        ext_a <= a;
        ext_b <= b;
    endtask

    // one falling edge per pulse
    // Wide pulses so the synchroniser sees each level
    task automatic pulse_a(input int n);
        repeat (n)
        begin
            @(posedge clk);
            cnt_a <= 1'b0;
            repeat (6) @(posedge clk);
            cnt_a <= 1'b1;
            repeat (6) @(posedge clk);
        end
    endtask
endmodule

//--- sim/dual_timer_ext_irq_unit_tb.sv
// Purpose: Self-checking bench for the dual timer and interrupt unit
// Assumes: One wait cycle per bus access, pins idle high
// Notes: Reads queue {mask, value}; a monitor compares at the answer edge
`timescale 1ns/1ns
module dual_timer_ext_irq_unit_tb;
    import dtei_pkg::*;
    logic clk;
    logic rst_n;
    dtei_avs_req_t avs_req;
    logic [DATA_W-1:0] avs_readdata;
    logic avs_waitrequest;
    logic ext_a;
    logic ext_b;
    logic cnt_a;
    logic cnt_b;
    logic [IRQ_W-1:0] vec_ack;
    logic irq;
    int n_errors;
    int total_checks;
    logic [15:0] exp_q[$];
    logic [15:0] ent;
    logic [7:0] rv;
    logic [7:0] ridx[8] = '{IDX_TCTL, IDX_TIMER_MODE_SELECT, IDX_TL_A, IDX_TL_B, IDX_TH_A, IDX_TH_B,
        IDX_CKPS, 8'h20};

    dtei_top dut (
        .clk(clk),
        .rst_n(rst_n),
        .avs_req(avs_req),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .ext_irq_a_pin(ext_a),
        .ext_irq_b_pin(ext_b),
        .timer_a_count_pin(cnt_a),
        .timer_b_count_pin(cnt_b),
        .vec_ack(vec_ack),
        .irq(irq)
    );

    dtei_pins pins (
        .clk(clk),
        .ext_a(ext_a),
        .ext_b(ext_b),
        .cnt_a(cnt_a),
        .cnt_b(cnt_b)
    );

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d);
        int n;
        @(posedge clk);
        avs_req.read <= !wr;
        avs_req.write <= wr;
        avs_req.address <= {idx, 2'b00};
        avs_req.byteenable <= 4'h1;
        avs_req.writedata <= {24'h000000, d};
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 100);
        avs_req.read <= 1'b0;
        avs_req.write <= 1'b0;
        if (n >= 100)
        begin
            n_errors++;
            summarize();
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [7:0] m, input logic [7:0] e);
        exp_q.push_back({m, e});
        bus(1'b0, idx, 8'h00);
    endtask

    task automatic vec(input logic [IRQ_W-1:0] v);
        @(posedge clk);
        vec_ack <= v;
        @(posedge clk);
        vec_ack <= '0;
    endtask

    always @(posedge clk)
    begin
        if (avs_req.read === 1'b1 && avs_waitrequest === 1'b0)
        begin
            if (exp_q.size() == 0)
                check("read without note", 8'h01, 8'h00);
            else
            begin
                ent = exp_q.pop_front();
                check("readdata", avs_readdata[7:0] & ent[15:8], ent[7:0]);
            end
        end
    end

    // Guard against a hang anywhere
    initial
    begin
        #900000;
        n_errors++;
        summarize();
    end

    initial
    begin
        avs_req = '0;
        vec_ack = '0;
        rst_n = 1'b0;
        n_errors = 0;
        total_checks = 0;
        void'($urandom(32'h96b65fb0));
        cyc(4);
        rst_n <= 1'b1;
        cyc(4);
        foreach (ridx[i])
            rd(ridx[i], 8'hff, (ridx[i] == IDX_CKPS) ? CKPS_RST : BYTE_ZERO);
        for (int i = 2; i < 6; i++)
        begin
            rv = 8'($urandom());
            wr(ridx[i], rv);
            rd(ridx[i], 8'hff, rv);
        end
        $display("test reset and count registers done");
        // 16-bit overflow of both timers at full clock rate
        wr(IDX_CLKCFG, 8'h03);
        wr(IDX_TIMER_MODE_SELECT, 8'h11);
        for (int i = 2; i < 6; i++)
            wr(ridx[i], (i < 4) ? 8'hf0 : BYTE_MAX);
        wr(IDX_TCTL, 8'h50);
        cyc(40);
        rd(IDX_TCTL, 8'ha0, 8'ha0);
        rd(IDX_TH_A, 8'hff, 8'h00);
        vec(4'h3);
        rd(IDX_TCTL, 8'ha0, 8'h00);
        wr(IDX_TCTL, 8'h00);
        wr(IDX_TL_A, 8'h55);
        cyc(30);
        rd(IDX_TL_A, 8'hff, 8'h55);
        $display("test overflow and run control done");
        // Mode 00: low five bits prescale the high byte
        wr(IDX_TIMER_MODE_SELECT, 8'h00);
        wr(IDX_TL_A, BYTE_MAX);
        wr(IDX_TH_A, 8'h00);
        wr(IDX_TCTL, 8'h10);
        cyc(10);
        wr(IDX_TCTL, 8'h00);
        rd(IDX_TH_A, 8'hff, 8'h01);
        rd(IDX_TL_A, 8'he0, 8'he0);
        // Mode 10: reload keeps the low byte at fe or ff
        wr(IDX_TIMER_MODE_SELECT, 8'h02);
        wr(IDX_TH_A, 8'hfe);
        wr(IDX_TL_A, 8'hfe);
        wr(IDX_TCTL, 8'h10);
        cyc(20);
        wr(IDX_TCTL, 8'h00);
        rd(IDX_TH_A, 8'hff, 8'hfe);
        rd(IDX_TL_A, 8'hfe, 8'hfe);
        $display("test modes 00 and 10 done");
        // Gate with the pin held low, then released
        wr(IDX_TIMER_MODE_SELECT, 8'h09);
        wr(IDX_TL_A, BYTE_MAX);
        wr(IDX_TH_A, BYTE_MAX);
        pins.set_ext(1'b0, 1'b1);
        // Let the low level through the synchroniser before running
        cyc(4);
        wr(IDX_TCTL, 8'h10);
        cyc(20);
        rd(IDX_TCTL, 8'h22, 8'h02);
        pins.set_ext(1'b1, 1'b1);
        cyc(20);
        rd(IDX_TCTL, 8'h22, 8'h20);
        $display("test gate and level detect done");
        // Counter mode from the count pin
        wr(IDX_TCTL, 8'h00);
        wr(IDX_TIMER_MODE_SELECT, 8'h05);
        wr(IDX_TL_A, 8'h00);
        wr(IDX_TCTL, 8'h10);
        pins.pulse_a(5);
        cyc(10);
        rd(IDX_TL_A, 8'hff, 8'h05);
        // Timer b mode 11 holds, timer a mode 11 splits
        wr(IDX_TIMER_MODE_SELECT, 8'h31);
        wr(IDX_TL_B, 8'h33);
        wr(IDX_TCTL, 8'h40);
        cyc(20);
        rd(IDX_TL_B, 8'hff, 8'h33);
        wr(IDX_TIMER_MODE_SELECT, 8'h03);
        wr(IDX_TL_A, 8'h44);
        wr(IDX_TH_A, 8'hf0);
        cyc(40);
        rd(IDX_TL_A, 8'hff, 8'h44);
        rd(IDX_TCTL, 8'h80, 8'h80);
        $display("test counter and mode 11 done");
        // Standard prescale: one count per 12 clocks
        wr(IDX_TCTL, 8'h00);
        wr(IDX_CLKCFG, 8'h00);
        wr(IDX_TIMER_MODE_SELECT, 8'h01);
        wr(IDX_TL_A, 8'h00);
        wr(IDX_TH_A, 8'h00);
        wr(IDX_TCTL, 8'h10);
        cyc(120);
        wr(IDX_TCTL, 8'h00);
        rd(IDX_TL_A, 8'hf8, 8'h08);
        // Fast select with divider 01: one count per 4 clocks
        wr(IDX_CKPS, 8'h09);
        wr(IDX_CLKCFG, 8'h40);
        wr(IDX_TL_A, 8'h00);
        wr(IDX_TCTL, 8'h10);
        cyc(40);
        wr(IDX_TCTL, 8'h00);
        rd(IDX_TL_A, 8'hf8, 8'h08);
        $display("test prescale done");
        // Edge detect, vectoring and the interrupt line
        wr(IDX_IMASK, 8'h04);
        rd(IDX_ISTAT, 8'h00, 8'h00);
        wr(IDX_TCTL, 8'h01);
        pins.set_ext(1'b0, 1'b1);
        cyc(8);
        pins.set_ext(1'b1, 1'b1);
        cyc(8);
        rd(IDX_TCTL, 8'h03, 8'h03);
        check("irq", {7'h00, irq}, 8'h01);
        vec(4'h4);
        rd(IDX_TCTL, 8'h03, 8'h01);
        rd(IDX_ISTAT, 8'h04, 8'h04);
        cyc(2);
        check("irq", {7'h00, irq}, 8'h00);
        wr(IDX_IMASK, 8'h00);
        pins.set_ext(1'b0, 1'b1);
        cyc(8);
        check("irq", {7'h00, irq}, 8'h00);
        rd(IDX_ISTAT, 8'h04, 8'h04);
        $display("test interrupts done");
        cyc(4);
        summarize();
    end
endmodule
